// ---- wwf_top.sv ----
// Wakeup frame filter bank: eight CRC-16 pattern filters behind Wishbone
// Assumes receive bytes, frame marks and regular filter verdict on sys_clk
//
// What this block does
// - Eight independent filters, each with mask, command, offset and reference CRC.
// - The 128-bit byte mask is four 32-bit words, word 0 lowest.
// - Mask bit zero of each word relates to the earliest of that word's 32 frame bytes.
// - Mask bit j set includes byte offset plus j in the CRC, else excluded.
// - Address type 00 considers only unicast frames.
// - Address type 10 considers only multicast frames.
// - Address type with low bit one considers frames passing the regular filter.
// - Command bit 0 enables the filter; disabled never matches; bit 1 reserved.
// - The offset selects where the filter starts examining frame bytes.
// - Offset is 8 bits; zero points at the first destination address byte.
// - A 16-bit reference CRC equal to the computed CRC marks a wakeup frame.
// - With detection enabled, a broadcast match wakes regardless of broadcast reject.
// - A unicast match wakes when global unicast enable bit 9 is set.
`default_nettype none
module wwf_top
   import wwf_pkg::*;
(
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [wwf_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   input  wire logic                      rxValid,
   input  wire logic                      rxSof,
   input  wire logic                      rxEof,
   input  wire logic [7:0]                rxData,
   input  wire logic                      rxPassFilter,
   output logic                           wakeFrame,
   output logic                           irq
);
   logic [31:0]      mask_q [NUM_FILT][4];
   logic [3:0]       cmd_q [NUM_FILT];
   logic [7:0]       offset_q [NUM_FILT];
   logic [15:0]      refCrc_q [NUM_FILT];
   logic             wakeEn_q;
   logic             ucastEn_q;
   logic [7:0]       irqSts_q;
   logic [7:0]       irqMsk_q;
   logic [31:0]      rdat_d;
   logic             ack_q;
   logic             wbReq;
   logic             wbWr;
   logic [15:0]      crcNow [NUM_FILT];
   logic [IDX_W-1:0] byteIdx;
   logic             isMcast;
   logic             isBcast;
   logic             pass_q;
   logic             mcast_q;
   logic             broadcast_reject_q;
   wwf_eval_t        evState_q;
   logic [7:0]       enVec;
   logic [7:0]       crcEq;
   logic [7:0]       matchVec;
   logic             wake_q;
   logic             irq_q;
   logic             frameEnd;
   logic             ucast;
   logic [31:0]      crcMerged;

   function automatic logic [31:0] laneMerge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int k = 0; k < 4; k++) begin
         if (s[k]) begin
            r[8*k +: 8] = n[8*k +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one wait state, every address acknowledged

   assign wbReq = wb_cyc_i && wb_stb_i && !ack_q;
   // Writes land at the ack edge, the one edge at which the master sees the answer
   assign wbWr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wbReq;
      end
   end

   always_comb begin
      rdat_d = '0;
      if (wb_adr_i < OFS_CMD) begin
         rdat_d = mask_q[wb_adr_i[6:4]][wb_adr_i[3:2]];
      end else if (wb_adr_i < OFS_OFFSET) begin
         // Reserved command bit reads as zero
         rdat_d[3:0] = cmd_q[wb_adr_i[4:2]] & ~(4'h1 << CMD_RSVD_BIT);
      end else if (wb_adr_i < OFS_CRC) begin
         rdat_d[7:0] = offset_q[wb_adr_i[4:2]];
      end else if (wb_adr_i < OFS_WAKE_CTRL) begin
         rdat_d[15:0] = refCrc_q[wb_adr_i[4:2]];
      end else if (wb_adr_i[7:2] == OFS_WAKE_CTRL[7:2]) begin
         rdat_d[WAKE_EN_BIT] = wakeEn_q;
         rdat_d[WAKE_RCVD_BIT] = |irqSts_q;
         rdat_d[UCAST_EN_BIT] = ucastEn_q;
      end else if (wb_adr_i[7:2] == OFS_IRQ_STS[7:2]) begin
         rdat_d[7:0] = irqSts_q;
      end else if (wb_adr_i[7:2] == OFS_IRQ_MSK[7:2]) begin
         rdat_d[7:0] = irqMsk_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_dat_o <= '0;
      end else if (wbReq) begin
         wb_dat_o <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;

   ////////////////////////////////////////////////////////////////////////////
   // Filter programming registers

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int f = 0; f < NUM_FILT; f++) begin
            for (int w = 0; w < 4; w++) begin
               mask_q[f][w] <= MASK_RST;
            end
         end
      end else if (wbWr && wb_adr_i < OFS_CMD) begin
         mask_q[wb_adr_i[6:4]][wb_adr_i[3:2]] <=
            laneMerge(mask_q[wb_adr_i[6:4]][wb_adr_i[3:2]], wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int f = 0; f < NUM_FILT; f++) begin
            cmd_q[f] <= CMD_RST;
         end
      end else if (wbWr && wb_adr_i >= OFS_CMD && wb_adr_i < OFS_OFFSET && wb_sel_i[0]) begin
         cmd_q[wb_adr_i[4:2]] <= wb_dat_i[3:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int f = 0; f < NUM_FILT; f++) begin
            offset_q[f] <= OFFSET_RST;
         end
      end else if (wbWr && wb_adr_i >= OFS_OFFSET && wb_adr_i < OFS_CRC && wb_sel_i[0]) begin
         offset_q[wb_adr_i[4:2]] <= wb_dat_i[7:0];
      end
   end

   assign crcMerged = laneMerge({16'h0000, refCrc_q[wb_adr_i[4:2]]}, wb_dat_i, wb_sel_i);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int f = 0; f < NUM_FILT; f++) begin
            refCrc_q[f] <= REFCRC_RST;
         end
      end else if (wbWr && wb_adr_i >= OFS_CRC && wb_adr_i < OFS_WAKE_CTRL) begin
         refCrc_q[wb_adr_i[4:2]] <= crcMerged[15:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wakeEn_q <= CTRL_RST[WAKE_EN_BIT];
         ucastEn_q <= CTRL_RST[UCAST_EN_BIT];
      end else if (wbWr && wb_adr_i[7:2] == OFS_WAKE_CTRL[7:2]) begin
         if (wb_sel_i[0]) begin
            wakeEn_q <= wb_dat_i[WAKE_EN_BIT];
         end
         if (wb_sel_i[1]) begin
            ucastEn_q <= wb_dat_i[UCAST_EN_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame tracking and the eight CRC lanes

   wwf_frame_class u_class (
      .sys_clk (sys_clk),
      .rst     (rst),
      .rxValid (rxValid),
      .rxSof   (rxSof),
      .rxData  (rxData),
      .byteIdx (byteIdx),
      .isMcast (isMcast),
      .isBcast (isBcast)
   );

   for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
      wwf_filter u_filt (
         .sys_clk   (sys_clk),
         .rst       (rst),
         .rxValid   (rxValid),
         .rxSof     (rxSof),
         .rxData    (rxData),
         .byteIdx   (byteIdx),
         .byteMask  ({mask_q[g][3], mask_q[g][2], mask_q[g][1], mask_q[g][0]}),
         .patOffset (offset_q[g]),
         .crcOut    (crcNow[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame-end judgement, one cycle after the last byte settles every CRC

   assign frameEnd = rxValid && rxEof;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pass_q <= 1'b0;
         mcast_q <= 1'b0;
         broadcast_reject_q <= 1'b0;
      end else if (frameEnd) begin
         pass_q <= rxPassFilter;
         mcast_q <= isMcast;
         broadcast_reject_q <= isBcast;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         evState_q <= EV_IDLE;
      end else begin
         case (evState_q)
            EV_IDLE: evState_q <= frameEnd ? EV_CHECK : EV_IDLE;
            EV_CHECK: evState_q <= frameEnd ? EV_CHECK : EV_IDLE;
            default: evState_q <= EV_IDLE;
         endcase
      end
   end

   assign ucast = !mcast_q;

   always_comb begin
      for (int f = 0; f < NUM_FILT; f++) begin
         enVec[f] = cmd_q[f][CMD_EN_BIT];
         crcEq[f] = crcNow[f] == refCrc_q[f];
         matchVec[f] = (evState_q == EV_CHECK) && wakeEn_q && enVec[f] && crcEq[f] &&
            (broadcast_reject_q ||
             (ucast && ucastEn_q) ||
             (pass_q && cmd_q[f][CMD_AT_LO]) ||
             (pass_q && cmd_q[f][CMD_AT_LO +: 2] == AT_MCAST && mcast_q) ||
             (pass_q && cmd_q[f][CMD_AT_LO +: 2] == AT_UCAST && ucast));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= |matchVec;
      end
   end

   assign wakeFrame = wake_q;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky per-filter status, write one to clear, set wins

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqSts_q <= '0;
      end else if (wbWr && wb_adr_i[7:2] == OFS_IRQ_STS[7:2] && wb_sel_i[0]) begin
         irqSts_q <= (irqSts_q & ~wb_dat_i[7:0]) | matchVec;
      end else begin
         irqSts_q <= irqSts_q | matchVec;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqMsk_q <= '0;
      end else if (wbWr && wb_adr_i[7:2] == OFS_IRQ_MSK[7:2] && wb_sel_i[0]) begin
         irqMsk_q <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irqSts_q & irqMsk_q);
      end
   end

   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_frame_end;
      rxValid && rxEof;
   endsequence

   sequence s_judged;
      evState_q == EV_CHECK;
   endsequence

   a_eval_at_end: assert property (s_frame_end |=> s_judged)
      else $error("frame end not judged next cycle");
   a_disabled_no_match: assert property ((matchVec & ~enVec) == 8'h00)
      else $error("disabled filter matched");
   a_broadcast_reject_wakes: assert property (
      s_judged ##0 (wakeEn_q && enVec[0] && crcEq[0] && broadcast_reject_q) |=> wake_q)
      else $error("broadcast match did not wake");
   a_ucast_global: assert property (
      s_judged ##0 (wakeEn_q && enVec[1] && crcEq[1] && ucast && ucastEn_q) |-> matchVec[1])
      else $error("global unicast match missed");
   a_mcast_type: assert property (
      (wakeEn_q && enVec[2] && crcEq[2] && pass_q && mcast_q && !broadcast_reject_q
       && cmd_q[2][3:2] == AT_MCAST) ##0 s_judged |-> matchVec[2])
      else $error("multicast type filter missed");
   a_ucast_type_only: assert property (
      (mcast_q && !broadcast_reject_q && cmd_q[0][3:2] == AT_UCAST) |-> !matchVec[0])
      else $error("unicast type filter took multicast");
   a_status_set_wins: assert property (
      (|matchVec) |=> (irqSts_q & $past(matchVec)) == $past(matchVec))
      else $error("status bit lost on match");
   a_wake_needs_en: assert property (
      wake_q |-> $past(wakeEn_q) && $past(evState_q) == EV_CHECK)
      else $error("wake without detection enabled");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
endmodule : wwf_top
`default_nettype wire

// ---- wwf_pkg.sv ----
// Constants shared by the wakeup frame filter bank
// Assumes a 32-bit classic Wishbone slave and byte-wide receive data
`default_nettype none
package wwf_pkg;
   localparam int NUM_FILT = 8;
   localparam int MASK_W = 128;
   localparam int IDX_W = 9;
   localparam int ADR_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_MASK = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h80;
   localparam logic [7:0] OFS_OFFSET = 8'ha0;
   localparam logic [7:0] OFS_CRC = 8'hc0;
   localparam logic [7:0] OFS_WAKE_CTRL = 8'he0;
   localparam logic [7:0] OFS_IRQ_STS = 8'he8;
   localparam logic [7:0] OFS_IRQ_MSK = 8'hec;
   // Command fields
   localparam int CMD_EN_BIT = 0;
   localparam int CMD_RSVD_BIT = 1;
   localparam int CMD_AT_LO = 2;
   localparam logic [1:0] AT_UCAST = 2'b00;
   localparam logic [1:0] AT_MCAST = 2'b10;
   // Wake control and status fields
   localparam int WAKE_EN_BIT = 2;
   localparam int WAKE_RCVD_BIT = 6;
   localparam int UCAST_EN_BIT = 9;
   // Reset values
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [3:0] CMD_RST = 4'h0;
   localparam logic [7:0] OFFSET_RST = 8'h00;
   localparam logic [15:0] REFCRC_RST = 16'h0000;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // CRC-16 engine
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [IDX_W-1:0] IDX_MAX = 9'h1ff;
   localparam logic [IDX_W-1:0] MASK_SPAN = 9'h080;
   localparam logic [7:0] BYTE_ONES = 8'hff;
   localparam int DA_BYTES = 6;
   typedef enum {EV_IDLE, EV_CHECK} wwf_eval_t;
endpackage : wwf_pkg
`default_nettype wire

// ---- wwf_frame_class.sv ----
// Tracks byte position and destination address class of a frame
// Assumes rxSof marks the first destination address byte
`default_nettype none
module wwf_frame_class
   import wwf_pkg::*;
(
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   input  wire logic                      rxValid,
   input  wire logic                      rxSof,
   input  wire logic [7:0]                rxData,
   output logic      [wwf_pkg::IDX_W-1:0] byteIdx,
   output logic                           isMcast,
   output logic                           isBcast
);
   logic [IDX_W-1:0] cnt_q;
   logic             mcast_q;
   logic             broadcast_reject_q;

   // Offset zero is the first destination address byte
   assign byteIdx = rxSof ? '0 : cnt_q;
   assign isMcast = mcast_q;
   assign isBcast = broadcast_reject_q;

   // Saturates so long frames never wrap into the mask window
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (rxValid) begin
         cnt_q <= (byteIdx == IDX_MAX) ? IDX_MAX : byteIdx + 9'd1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mcast_q <= 1'b0;
         broadcast_reject_q <= 1'b0;
      end else if (rxValid && rxSof) begin
         mcast_q <= rxData[0];
         broadcast_reject_q <= (rxData == BYTE_ONES);
      end else if (rxValid && byteIdx < IDX_W'(DA_BYTES)) begin
         broadcast_reject_q <= broadcast_reject_q && (rxData == BYTE_ONES);
      end
   end
endmodule : wwf_frame_class
`default_nettype wire

// ---- wwf_filter.sv ----
// One filter lane: CRC-16 over the masked bytes of the current frame
// Assumes byteIdx is the position of the byte presented this cycle
`default_nettype none
module wwf_filter
   import wwf_pkg::*;
(
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   input  wire logic                       rxValid,
   input  wire logic                       rxSof,
   input  wire logic [7:0]                 rxData,
   input  wire logic [wwf_pkg::IDX_W-1:0]  byteIdx,
   input  wire logic [wwf_pkg::MASK_W-1:0] byteMask,
   input  wire logic [7:0]                 patOffset,
   output logic      [15:0]                crcOut
);
   logic [15:0]      crc_q;
   logic [15:0]      base;
   logic [IDX_W-1:0] rel;
   logic             inWin;
   logic             take;

   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      // Bits enter in wire order, least significant first
      for (int b = 0; b < 8; b++) begin
         r = r[15] ^ d[b] ? {r[14:0], 1'b0} ^ CRC_POLY : {r[14:0], 1'b0};
      end
      return r;
   endfunction

   assign rel = byteIdx - {1'b0, patOffset};
   assign inWin = (byteIdx >= {1'b0, patOffset}) && (rel < MASK_SPAN);
   assign take = inWin && byteMask[rel[6:0]];
   assign base = rxSof ? CRC_INIT : crc_q;
   assign crcOut = crc_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         crc_q <= CRC_INIT;
      end else if (rxValid) begin
         crc_q <= take ? crcByte(base, rxData) : base;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_window_end_hold: assert property (
      rxValid && !rxSof && rel >= MASK_SPAN |=> crc_q == $past(crc_q))
      else $error("byte beyond window changed the CRC");
   a_mask_clear_hold: assert property (
      rxValid && !rxSof && !byteMask[rel[6:0]] |=> crc_q == $past(crc_q))
      else $error("masked-out byte changed the CRC");
   a_frame_restart: assert property (
      rxValid && rxSof && !take |=> crc_q == CRC_INIT)
      else $error("CRC not restarted at frame start");
endmodule : wwf_filter
`default_nettype wire

// ---- wwf_rx_model.sv ----
// Receive byte source standing in for the MAC receive datapath
// Assumes the bench fills frm and calls send from a single thread
`default_nettype none
module wwf_rx_model (
   input  wire logic       sys_clk,
   output logic            rxValid,
   output logic            rxSof,
   output logic            rxEof,
   output logic [7:0]      rxData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] frm [0:255];
   initial begin
      rxValid = 1'b0;
      rxSof   = 1'b0;
      rxEof   = 1'b0;
      rxData  = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Gaps show inverted data so a stale byte never looks like a valid one
   task automatic send(input int len, input int gap);
      for (int i = 0; i < len; i++) begin
         @(posedge sys_clk);
         rxValid <= 1'b1;
         rxSof   <= (i == 0);
         rxEof   <= (i == len - 1);
         rxData  <= frm[i];
         repeat (gap) begin
            @(posedge sys_clk);
            rxValid <= 1'b0;
            rxData  <= ~frm[i];
         end
      end
      @(posedge sys_clk);
      rxValid <= 1'b0;
      rxSof   <= 1'b0;
      rxEof   <= 1'b0;
      rxData  <= ~frm[len - 1];
   endtask
endmodule // wwf_rx_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the wakeup frame filter bank
// Assumes wwf_top and the receive source model are compiled before it
`default_nettype none
module testbench
   import wwf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int FLEN = 200;
   logic         sys_clk = 1'b0;
   logic         rst = 1'b1;
   logic         wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, rxPass = 1'b0;
   logic [7:0]   wbAdr = 8'h00;
   logic [3:0]   wbSel = 4'hf, selReq = 4'hf;
   logic [31:0]  wbDatI = 32'h0, wbDatO;
   logic         wbAck, rxValid, rxSof, rxEof, wakeFrame, irq;
   logic [7:0]   rxData;
   logic [127:0] mskv [8];
   logic [7:0]   ofsv [8];
   logic [3:0]   cmdv [8];
   logic [15:0]  refv [8];
   int           mismatches = 0, cmp_count = 0, pulses = 0;

   wwf_top wwf_top_inst (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof),
      .rxData(rxData), .rxPassFilter(rxPass), .wakeFrame(wakeFrame), .irq(irq));
   wwf_rx_model wwf_rx_model_inst (.sys_clk(sys_clk), .rxValid(rxValid), .rxSof(rxSof),
      .rxEof(rxEof), .rxData(rxData));

   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (wakeFrame === 1'b1) pulses++;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Request held until ack is sampled; no fixed latency assumed
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge sys_clk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbSel  <= selReq;
      wbAdr  <= a;
      wbDatI <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1, "bus ack missing");
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      wb(1'b1, a, d, x);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] got;
      wb(1'b0, a, 32'h0, got);
      chk(got, exp, what);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Reference CRC: masked bytes only, LSB first, never past the frame end
   function automatic logic [15:0] crc_of(input int f);
      logic [15:0] c;
      logic [7:0]  b;
      logic        fb;
      c = 16'hffff;
      for (int j = 0; j < 128; j++) begin
         if (mskv[f][j] && int'(ofsv[f]) + j < FLEN) begin
            b = wwf_rx_model_inst.frm[int'(ofsv[f]) + j];
            for (int k = 0; k < 8; k++) begin
               fb = c[15] ^ b[k];
               c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0);
            end
         end
      end
      return c;
   endfunction

   // Kind 0 unicast, 1 multicast, 2 broadcast; only the address bytes differ
   task automatic build(input int kind);
      for (int i = 0; i < FLEN; i++) wwf_rx_model_inst.frm[i] = 8'(i * 29 + 11);
      for (int i = 1; i < DA_BYTES; i++) if (kind == 2) wwf_rx_model_inst.frm[i] = 8'hff;
      wwf_rx_model_inst.frm[0] = (kind == 0) ? 8'h02 : (kind == 1) ? 8'h01 : 8'hff;
   endtask

   task automatic frame(input int kind, input logic pass, input logic uen, input logic wen);
      logic [7:0] exp, imsk;
      logic       uc, mc, bc;
      exp  = 8'h00;
      imsk = 8'(8'h05 << kind);
      uc   = (kind == 0);
      mc   = (kind != 0);
      bc   = (kind == 2);
      wr(OFS_WAKE_CTRL, {22'h0, uen, 6'h0, wen, 2'h0});
      wr(OFS_IRQ_MSK, {24'h0, imsk});
      build(kind);
      for (int f = 0; f < NUM_FILT; f++)
         if (cmdv[f][0] && crc_of(f) === refv[f] && wen && (bc || (uc && uen) ||
             (pass && (cmdv[f][2] || (cmdv[f][3:2] == AT_MCAST && mc) ||
             (cmdv[f][3:2] == AT_UCAST && uc))))) exp[f] = 1'b1;
      rxPass <= pass;
      pulses = 0;
      wwf_rx_model_inst.send(FLEN, kind);
      repeat (6) @(posedge sys_clk);
      chk(32'(pulses), 32'(exp != 8'h0), "wake pulse count");
      rdchk(OFS_IRQ_STS, {24'h0, exp}, "filter status");
      rdchk(OFS_WAKE_CTRL, {22'h0, uen, 2'h0, |exp, 3'h0, wen, 2'h0}, "wake control");
      chk(32'(irq), 32'(|(exp & imsk)), "irq level");
      wr(OFS_IRQ_STS, 32'hff);
      rdchk(OFS_IRQ_STS, 32'h0, "status after clear");
      chk(32'(irq), 32'h0, "irq after clear");
      $display("test frame kind %0d pass %0d ucast %0d detect %0d done", kind, pass, uen, wen);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      $display("ERROR t=%0t watchdog expired", $time);
      wrap_up();
   end

   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rdchk(OFS_CMD, 32'h0, "command reset value");
      rdchk(8'hf0, 32'h0, "unmapped read");
      build(0);
      // Masks skip the address bytes so one reference serves every frame kind
      for (int f = 0; f < NUM_FILT; f++) begin
         mskv[f] = 128'h5 << (f * 17 + 6);
         if (f == 1) mskv[f][127] = 1'b1;
         ofsv[f] = 8'(f * 36);
         cmdv[f] = (f == 4) ? 4'h2 : {2'(f), 2'b11};
         refv[f] = crc_of(f) ^ ((f == 5) ? 16'h1 : 16'h0);
         for (int w = 0; w < 4; w++) wr(8'(16 * f + 4 * w), mskv[f][32 * w +: 32]);
         wr(8'(OFS_CMD + 4 * f), {28'h0, cmdv[f]});
         wr(8'(OFS_OFFSET + 4 * f), {24'h0, ofsv[f]});
         wr(8'(OFS_CRC + 4 * f), {16'h0, refv[f]});
      end
      for (int f = 0; f < NUM_FILT; f++) begin
         rdchk(8'(16 * f + 12), mskv[f][127:96], "mask word 3");
         rdchk(8'(OFS_CMD + 4 * f), {28'h0, cmdv[f] & 4'hd}, "command");
         rdchk(8'(OFS_OFFSET + 4 * f), {24'h0, ofsv[f]}, "offset");
         rdchk(8'(OFS_CRC + 4 * f), {16'h0, refv[f]}, "reference crc");
      end
      $display("test register access done");
      // Byte lanes: only the enabled lanes of a word may change
      selReq = 4'he;
      wr(OFS_OFFSET, 32'hff);
      selReq = 4'h2;
      wr(8'h00, 32'hffff_ffff);
      selReq = 4'h1;
      wr(OFS_CRC, 32'hffff_ffff);
      selReq = 4'hf;
      rdchk(OFS_OFFSET, {24'h0, ofsv[0]}, "offset with lane 0 off");
      rdchk(8'h00, mskv[0][31:0] | 32'h0000_ff00, "mask lane 1 only");
      rdchk(OFS_CRC, {16'h0, refv[0][15:8], 8'hff}, "crc lane 0 only");
      wr(8'h00, mskv[0][31:0]);
      wr(OFS_CRC, {16'h0, refv[0]});
      $display("test byte lanes done");
      for (int k = 0; k < 3; k++)
         for (int p = 0; p < 2; p++)
            for (int u = 0; u < 2; u++) frame(k, p[0], u[0], 1'b1);
      frame(2, 1'b1, 1'b1, 1'b0);
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
